/* hw/perf_monitor_top.sv */
// bus, snoop and floating-point event counters with monitor pins
`default_nettype none
`include "perf_consts.svh"
module perf_monitor_top #(
    parameter int CW = 40
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`PM_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic mem_done_self_pin,
    input wire logic mem_done_any_pin,
    input wire logic data_receive_pin,
    input wire logic block_next_request_pin,
    input wire logic clean_snoop_drive_pin,
    input wire logic modified_snoop_match_pin,
    input wire logic snoop_stall_pin,
    input wire logic fp_retire,
    input wire logic fp_retire_excluded,
    input wire logic fp_assist_op,
    input wire logic fp_subop,
    output logic [1:0] monitor_output_pin
);
    // reset release
    logic rst_a_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_a_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n_q <= rst_a_q;
        end
    end

    // pin synchronisers
    logic [`PM_PIN_COUNT-1:0] pin_raw;
    logic [`PM_PIN_COUNT-1:0] pin_a_q;
    logic [`PM_PIN_COUNT-1:0] pin_q;

    assign pin_raw = {
        snoop_stall_pin,
        modified_snoop_match_pin,
        clean_snoop_drive_pin,
        block_next_request_pin,
        data_receive_pin,
        mem_done_any_pin,
        mem_done_self_pin
    };

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_a_q <= '0;
            pin_q <= '0;
        end else begin
            pin_a_q <= pin_raw;
            pin_q <= pin_a_q;
        end
    end

    // one synchronised level per far-side pin
    logic mem_self;
    logic mem_any;
    logic rcv_act;
    logic flow_act;
    logic hit_act;
    logic mod_act;
    logic stall_act;

    assign mem_self = pin_q[0];
    assign mem_any = pin_q[1];
    assign rcv_act = pin_q[2];
    assign flow_act = pin_q[3];
    assign hit_act = pin_q[4];
    assign mod_act = pin_q[5];
    assign stall_act = pin_q[6];

    // software registers
    logic [31:0] sel_q [2];
    logic [`PM_RATIO_W-1:0] ratio_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sel_q[0] <= `PM_SEL_RESET;
            sel_q[1] <= `PM_SEL_RESET;
        end else if (wr_stb) begin
            if (addr == `PM_SEL0_OFS) begin
                sel_q[0] <= wdata & `PM_SEL_MASK;
            end
            if (addr == `PM_SEL1_OFS) begin
                sel_q[1] <= wdata & `PM_SEL_MASK;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ratio_q <= `PM_RATIO_RESET;
        end else if (wr_stb && addr == `PM_RATIO_OFS) begin
            ratio_q <= wdata[`PM_RATIO_W-1:0];
        end
    end

    // bus clock enable from the core-to-bus ratio
    logic [`PM_RATIO_W-1:0] div_q;
    logic bus_tick_q;
    logic div_wrap;

    // ratio 0 or 1: bus runs at the core rate
    assign div_wrap = (ratio_q <= `PM_RATIO_W'(1)) ||
                      (div_q >= ratio_q - `PM_RATIO_W'(1));

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= '0;
            bus_tick_q <= 1'b0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + `PM_RATIO_W'(1);
            bus_tick_q <= div_wrap;
        end
    end

    logic ratio_ok;

    assign ratio_ok = (ratio_q == `PM_RATIO_TWO) ||
                      (ratio_q == `PM_RATIO_THREE);

    // retired floating-point operations this cycle
    logic [1:0] fp_inc;
    logic fp_keep;

    assign fp_keep = fp_retire & ~fp_retire_excluded;

    always_comb begin
        fp_inc = 2'(fp_keep);
        fp_inc = fp_inc + 2'(fp_assist_op);
        fp_inc = fp_inc + 2'(fp_subop);
    end

    // event decode
    // unlisted codes or unit masks give no event; 7AH takes any unit mask
    function automatic perf_pkg::ev_kind_t decode_ev(
        input logic [7:0] code,
        input logic [7:0] umask
    );
        perf_pkg::ev_kind_t kind;
        kind = perf_pkg::EV_NONE;
        case (code)
            `PM_EV_MEM: begin
                if (umask == `PM_UM_SELF || umask == `PM_UM_ANY) begin
                    kind = perf_pkg::EV_MEM;
                end
            end
            `PM_EV_RCV: begin
                if (umask == `PM_UM_SELF) begin
                    kind = perf_pkg::EV_RCV;
                end
            end
            `PM_EV_FLOW: begin
                if (umask == `PM_UM_SELF) begin
                    kind = perf_pkg::EV_FLOW;
                end
            end
            `PM_EV_HIT: begin
                kind = perf_pkg::EV_HIT;
            end
            `PM_EV_MOD: begin
                if (umask == `PM_UM_SELF) begin
                    kind = perf_pkg::EV_MOD;
                end
            end
            `PM_EV_STALL: begin
                if (umask == `PM_UM_SELF) begin
                    kind = perf_pkg::EV_STALL;
                end
            end
            `PM_EV_FP: begin
                if (umask == `PM_UM_SELF) begin
                    kind = perf_pkg::EV_FP;
                end
            end
            default: begin
                kind = perf_pkg::EV_NONE;
            end
        endcase
        return kind;
    endfunction

    logic [CW-1:0] count [2];
    logic [1:0] ovf;
    logic [1:0] mon_q;
    logic [1:0] snoop_sel;
    logic [1:0] pc_sel;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_lane
            perf_pkg::ev_kind_t kind;
            logic [1:0] inc;
            logic enabled;
            logic any_agent;

            assign kind = decode_ev(
                sel_q[i][`PM_EVT_MSB:`PM_EVT_LSB],
                sel_q[i][`PM_UMASK_MSB:`PM_UMASK_LSB]);
            assign enabled = sel_q[i][`PM_EN_BIT];
            assign any_agent =
                sel_q[i][`PM_UMASK_MSB:`PM_UMASK_LSB] == `PM_UM_ANY;
            assign pc_sel[i] = sel_q[i][`PM_PIN_CTL_BIT];
            assign snoop_sel[i] = (kind == perf_pkg::EV_HIT) ||
                                  (kind == perf_pkg::EV_MOD);

            always_comb begin
                inc = 2'b00;
                if (enabled) begin
                    unique case (kind)
                        perf_pkg::EV_MEM: begin
                            if (bus_tick_q) begin
                                inc = 2'(any_agent ? mem_any
                                                   : mem_self);
                            end
                        end
                        perf_pkg::EV_RCV: begin
                            inc = 2'(bus_tick_q & rcv_act);
                        end
                        perf_pkg::EV_FLOW: begin
                            inc = 2'(bus_tick_q & flow_act);
                        end
                        perf_pkg::EV_HIT: begin
                            inc = 2'(bus_tick_q & hit_act);
                        end
                        perf_pkg::EV_MOD: begin
                            inc = 2'(bus_tick_q & mod_act);
                        end
                        perf_pkg::EV_STALL: begin
                            inc = 2'(stall_act);
                        end
                        perf_pkg::EV_FP: begin
                            if (i == 0) begin
                                inc = fp_inc;
                            end else begin
                                inc = 2'b00;
                            end
                        end
                        perf_pkg::EV_NONE: begin
                            inc = 2'b00;
                        end
                    endcase
                end
            end

            event_counter_lane #(
                .CW(CW)
            ) u_lane (
                .clk(clk),
                .rst_n(rst_n_q),
                .inc(inc),
                .load_lo(wr_stb && addr == (i == 0 ? `PM_CTR0_LO_OFS
                                                   : `PM_CTR1_LO_OFS)),
                .load_hi(wr_stb && addr == (i == 0 ? `PM_CTR0_HI_OFS
                                                   : `PM_CTR1_HI_OFS)),
                .wdata(wdata),
                .count(count[i]),
                .ovf(ovf[i])
            );

            // monitor pin: pulse or toggle on overflow
            // the ratio gate mutes only the 7AH and 7BH snoop events
            always_ff @(posedge clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    mon_q[i] <= 1'b0;
                end else if (snoop_sel[i] && !ratio_ok) begin
                    mon_q[i] <= 1'b0;
                end else if (pc_sel[i]) begin
                    mon_q[i] <= ovf[i];
                end else if (ovf[i]) begin
                    mon_q[i] <= ~mon_q[i];
                end
            end
        end
    endgenerate

    assign monitor_output_pin = mon_q;

    // read port, data in the cycle after the strobe only
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr)
            `PM_SEL0_OFS: begin
                rd_mux = sel_q[0];
            end
            `PM_SEL1_OFS: begin
                rd_mux = sel_q[1];
            end
            `PM_CTR0_LO_OFS: begin
                rd_mux = count[0][31:0];
            end
            `PM_CTR0_HI_OFS: begin
                rd_mux[CW-33:0] = count[0][CW-1:32];
            end
            `PM_CTR1_LO_OFS: begin
                rd_mux = count[1][31:0];
            end
            `PM_CTR1_HI_OFS: begin
                rd_mux[CW-33:0] = count[1][CW-1:32];
            end
            `PM_RATIO_OFS: begin
                rd_mux[`PM_RATIO_W-1:0] = ratio_q;
            end
            // status: monitor pins and ratio-supported flag
            `PM_STATUS_OFS: begin
                rd_mux[`PM_STAT_OK_BIT-1:0] = mon_q;
                rd_mux[`PM_STAT_OK_BIT] = ratio_ok;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_stb) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign rdata = rdata_q;
endmodule
`default_nettype wire

/* hw/perf_consts.svh */
// register offsets, field positions and event codes for the monitor
// How it works
// - 6FH counts memory transactions, self or any
// - 64H counts bus clocks receiving data
// - 61H counts bus clocks driving block-next-request
// - 7AH counts bus clocks driving clean snoop
// - 7BH counts bus clocks driving modified snoop
// - 7EH counts clocks of bus snoop stall
// - both selects hold pin-control bit 19
// - ratio 2:1/3:1, bit set: one-clock pulse
// - pin-control clear: output toggles on overflow
// - other ratios: no snoop-event overflow indication
// - C1H counts retired FP ops, counter 0
// - trapped or assisted FP ops not counted
// - assist-handler ops and sub-ops are counted
`ifndef PERF_CONSTS_SVH
`define PERF_CONSTS_SVH

`define PM_ADDR_W 4
`define PM_SEL0_OFS 4'h0
`define PM_SEL1_OFS 4'h1
`define PM_CTR0_LO_OFS 4'h2
`define PM_CTR0_HI_OFS 4'h3
`define PM_CTR1_LO_OFS 4'h4
`define PM_CTR1_HI_OFS 4'h5
`define PM_RATIO_OFS 4'h6
`define PM_STATUS_OFS 4'h7

`define PM_EVT_LSB 0
`define PM_EVT_MSB 7
`define PM_UMASK_LSB 8
`define PM_UMASK_MSB 15
`define PM_PIN_CTL_BIT 19
`define PM_EN_BIT 22
`define PM_SEL_RESET 32'h0000_0000
`define PM_SEL_MASK 32'h0048_FFFF

`define PM_RATIO_W 4
`define PM_RATIO_RESET 4'h2
`define PM_RATIO_TWO 4'h2
`define PM_RATIO_THREE 4'h3

`define PM_EV_MEM 8'h6F
`define PM_EV_RCV 8'h64
`define PM_EV_FLOW 8'h61
`define PM_EV_HIT 8'h7A
`define PM_EV_MOD 8'h7B
`define PM_EV_STALL 8'h7E
`define PM_EV_FP 8'hC1
`define PM_UM_SELF 8'h00
`define PM_UM_ANY 8'h20

`define PM_PIN_COUNT 7
`define PM_STAT_OK_BIT 2

`endif

/* hw/perf_pkg.sv */
// types shared by the performance monitor
`default_nettype none
package perf_pkg;
    typedef enum logic [7:0] {
        EV_NONE = 8'h01,
        EV_MEM = 8'h02,
        EV_RCV = 8'h04,
        EV_FLOW = 8'h08,
        EV_HIT = 8'h10,
        EV_MOD = 8'h20,
        EV_STALL = 8'h40,
        EV_FP = 8'h80
    } ev_kind_t;
endpackage
`default_nettype wire

/* hw/event_counter_lane.sv */
// one loadable event counter with an overflow pulse
`default_nettype none
`include "perf_consts.svh"
module event_counter_lane #(
    parameter int CW = 40
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] inc,
    input wire logic load_lo,
    input wire logic load_hi,
    input wire logic [31:0] wdata,
    output logic [CW-1:0] count,
    output logic ovf
);
    logic [CW-1:0] count_q;
    logic ovf_q;
    logic [CW:0] sum;

    assign sum = {1'b0, count_q} + {{(CW-1){1'b0}}, inc};
    assign count = count_q;
    assign ovf = ovf_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (load_lo) begin
            count_q[31:0] <= wdata;
        end else if (load_hi) begin
            count_q[CW-1:32] <= wdata[CW-33:0];
        end else begin
            count_q <= sum[CW-1:0];
        end
    end

    // wrap of the counter, not raised by software loads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= sum[CW] & ~load_lo & ~load_hi;
        end
    end
endmodule
`default_nettype wire

/* verif/perf_monitor_assertions.sv */
// assertions on the register port and the monitor pins
`default_nettype none
`include "perf_consts.svh"
module perf_monitor_assertions #(
    parameter int CW = 40
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`PM_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire logic [1:0] monitor_output_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] sel0_q;
    logic [31:0] sel1_q;
    logic [3:0] ratio_q;
    logic mute;
    // shadow of the selects and the ratio
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel0_q <= `PM_SEL_RESET;
            sel1_q <= `PM_SEL_RESET;
            ratio_q <= `PM_RATIO_RESET;
        end else if (wr_stb) begin
            if (addr == `PM_SEL0_OFS) sel0_q <= wdata & `PM_SEL_MASK;
            if (addr == `PM_SEL1_OFS) sel1_q <= wdata & `PM_SEL_MASK;
            if (addr == `PM_RATIO_OFS) ratio_q <= wdata[3:0];
        end
    end
    assign mute = (sel0_q[7:0] == `PM_EV_HIT || sel0_q[7:0] == `PM_EV_MOD)
        && ratio_q != `PM_RATIO_TWO && ratio_q != `PM_RATIO_THREE;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_rd_idle;
        !$past(rd_stb) |-> rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read slot");
    property p_unmapped;
        $past(rd_stb) && $past(addr) > 4'h7 |-> rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped index read not zero");
    property p_hi_read;
        $past(rd_stb) && ($past(addr) == `PM_CTR0_HI_OFS
            || $past(addr) == `PM_CTR1_HI_OFS) |-> rdata[31:8] == 24'h0;
    endproperty
    a_hi_read: assert property (p_hi_read)
        else $error("counter high half has upper bits set");
    property p_sel_read;
        $past(rd_stb) && $past(addr) < 4'h2 |-> rdata ==
            ($past(addr) == `PM_SEL0_OFS ? $past(sel0_q) : $past(sel1_q));
    endproperty
    a_sel_read: assert property (p_sel_read)
        else $error("select readback differs from written value");
    property p_ratio_read;
        $past(rd_stb) && $past(addr) == `PM_RATIO_OFS
            |-> rdata == {28'h0, $past(ratio_q)};
    endproperty
    a_ratio_read: assert property (p_ratio_read)
        else $error("ratio readback wrong");
    property p_pulse_one;
        sel0_q[19] && $rose(monitor_output_pin[0]) |=> !monitor_output_pin[0];
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("monitor pulse not one clock");
    property p_toggle_hold;
        !sel0_q[19] && !mute && $rose(monitor_output_pin[0])
            |=> monitor_output_pin[0] [*3];
    endproperty
    a_toggle_hold: assert property (p_toggle_hold)
        else $error("toggled monitor pin did not hold");
    property p_mute;
        mute && $past(mute) && $past(mute, 2) |-> !monitor_output_pin[0];
    endproperty
    a_mute: assert property (p_mute)
        else $error("monitor pin active at unsupported ratio");
    property p_rst_quiet;
        $rose(rst_b) |-> (monitor_output_pin == 2'b00) [*2];
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("monitor pins active right after reset");
    c_pulse: cover property (sel0_q[19] && $rose(monitor_output_pin[0]));
    c_toggle: cover property (!sel0_q[19] && $rose(monitor_output_pin[0]));
    c_mute: cover property (mute && sel0_q[22]);
endmodule
`default_nettype wire

/* verif/far_bus_agents.sv */
// other bus agents driving the snoop and transfer pins
`default_nettype none
module far_bus_agents (
    input wire logic clk,
    input wire logic slow,
    input wire logic [6:0] want,
    output logic [6:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] lag_q;
    // slow agents answer one clock edge later
    always_ff @(posedge clk) begin
        lag_q <= want;
        pins <= slow ? lag_q : want;
    end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the bus, snoop and fp event counters
`default_nettype none
`include "perf_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] EN = 32'h0040_0000;
    localparam logic [31:0] PIN_CTL = 32'h0008_0000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rdata;
    logic [6:0] want = 7'h00;
    logic slow = 1'b0;
    logic [6:0] pins;
    logic [3:0] fp = 4'h0;
    logic [1:0] mon;
    logic [7:0] lfsr = 8'h55;
    logic [7:0] codes [8] = '{8'h6F, 8'h6F, 8'h64, 8'h61, 8'h7A, 8'h7B,
        8'h7E, 8'h7B};
    logic [6:0] pmask [8] = '{7'h03, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20,
        7'h40, 7'h20};
    logic [3:0] ratios [8] = '{4'h2, 4'h3, 4'h0, 4'h2, 4'h3, 4'h2, 4'h3, 4'h5};
    logic [31:0] rst_vals [8] = '{0, 0, 0, 0, 0, 0, 2, 4};
    int fails = 0;
    int num_checks = 0;
    int mon_hi = 0;
    int mon1_hi = 0;
    always #20 clk = ~clk;
    always @(negedge clk) begin
        mon_hi += mon[0];
        mon1_hi += mon[1];
    end
    far_bus_agents agents (.clk(clk), .slow(slow), .want(want), .pins(pins));
    perf_monitor_top #(.CW(40)) dut (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .mem_done_self_pin(pins[0]), .mem_done_any_pin(pins[1]),
        .data_receive_pin(pins[2]), .block_next_request_pin(pins[3]),
        .clean_snoop_drive_pin(pins[4]), .modified_snoop_match_pin(pins[5]),
        .snoop_stall_pin(pins[6]), .fp_retire(fp[0]),
        .fp_retire_excluded(fp[1]), .fp_assist_op(fp[2]), .fp_subop(fp[3]),
        .monitor_output_pin(mon));
    function automatic logic [7:0] step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // expected count for a level held n cycles at a given ratio
    function automatic int bus_exp(input logic [7:0] c, input logic [7:0] um,
            input logic [6:0] p, input int r, input int n);
        int hit;
        hit = 0;
        case (c)
            8'h6F: hit = um == 8'h20 ? p[1] : (um == 8'h00) & p[0];
            8'h64: hit = (um == 8'h00) & p[2];
            8'h61: hit = (um == 8'h00) & p[3];
            8'h7A: hit = p[4];
            8'h7B: hit = (um == 8'h00) & p[5];
            8'h7E: return (um == 8'h00 && p[6]) ? n : 0;
            default: hit = 0;
        endcase
        return hit ? n / (r < 2 ? 1 : r) : 0;
    endfunction
    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_ctr(input int i, input int e);
        logic [31:0] lo;
        logic [31:0] hi;
        rd(4'(2 + 2 * i), lo);
        rd(4'(3 + 2 * i), hi);
        cmp({hi[7:0], lo}, 40'(e) & 40'hFF_FFFF_FFFF);
    endtask
    task automatic arm(input logic [31:0] s0, input logic [31:0] s1,
            input logic [3:0] r, input logic [39:0] pre);
        wr(`PM_SEL0_OFS, 32'h0);
        wr(`PM_SEL1_OFS, 32'h0);
        wr(`PM_CTR0_LO_OFS, pre[31:0]);
        wr(`PM_CTR0_HI_OFS, {24'h0, pre[39:32]});
        wr(`PM_CTR1_LO_OFS, pre[31:0]);
        wr(`PM_CTR1_HI_OFS, {24'h0, pre[39:32]});
        wr(`PM_RATIO_OFS, {28'h0, r});
        wr(`PM_SEL1_OFS, s1);
        wr(`PM_SEL0_OFS, s0);
        repeat (3) @(posedge clk);
        mon_hi = 0;
        mon1_hi = 0;
    endtask
    task automatic drive(input logic [6:0] p, input int n);
        @(posedge clk);
        want <= p;
        repeat (n) @(posedge clk);
        want <= 7'h00;
        repeat (8) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] d;
        int n;
        int exp;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(4'(i), d);
            cmp(d, rst_vals[i]);
        end
        wr(4'hA, 32'hFFFF_FFFF);
        rd(4'hA, d);
        cmp(d, 32'h0);
        for (int i = 0; i < 2; i++) begin
            wr(4'(i), 32'hFFFF_FFFF);
            rd(4'(i), d);
            cmp(d, 32'h0048_FFFF);
        end
        for (int i = 0; i < 8; i++) begin
            n = 30 * (1 + lfsr[0]);
            slow <= lfsr[1];
            lfsr = step(lfsr);
            arm(EN | {16'h0, 8'h00, codes[i]}, EN | {16'h0, 8'h20, codes[i]},
                ratios[i], 40'h0);
            drive(pmask[i], n);
            exp = bus_exp(codes[i], 8'h00, pmask[i], ratios[i], n);
            rd_ctr(0, exp);
            exp = bus_exp(codes[i], 8'h20, pmask[i], ratios[i], n);
            rd_ctr(1, exp);
        end
        arm(EN | PIN_CTL | 32'h7A, 32'h0, 4'h3, 40'hFF_FFFF_FFFF);
        drive(7'h10, 9);
        cmp(40'(mon_hi), 40'd1);
        rd_ctr(0, 2);
        arm(EN | 32'h7B, EN | PIN_CTL | 32'h7B, 4'h2, 40'hFF_FFFF_FFFF);
        drive(7'h20, 8);
        cmp(40'(mon1_hi), 40'd1);
        rd_ctr(1, 3);
        rd(`PM_STATUS_OFS, d);
        cmp(d, 32'h5);
        arm(EN | PIN_CTL | 32'h7B, 32'h0, 4'h5, 40'hFF_FFFF_FFFF);
        drive(7'h20, 10);
        cmp(40'(mon_hi), 40'd0);
        rd_ctr(0, 1);
        arm(EN | 32'hC1, EN | 32'hC1, 4'h2, 40'h0);
        exp = 0;
        repeat (40) begin
            @(posedge clk);
            fp <= lfsr[3:0];
            exp += (lfsr[0] & ~lfsr[1]) + lfsr[2] + lfsr[3];
            lfsr = step(lfsr);
        end
        @(posedge clk);
        fp <= 4'h0;
        repeat (4) @(posedge clk);
        rd_ctr(0, exp);
        rd_ctr(1, 0);
        tally_and_finish;
    end
    initial begin
        #800000;
        fails++;
        tally_and_finish;
    end
endmodule
bind perf_monitor_top perf_monitor_assertions #(.CW(CW)) chk (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .monitor_output_pin(monitor_output_pin));
`default_nettype wire
